// File: pkg/umw_pkg.sv
// Types shared by the upstream memory window block
package umw_pkg;
  typedef logic [31:0] umw_word_type;
  typedef logic [63:0] umw_addr_type;
  typedef logic [11:0] umw_off_type;
  typedef enum logic [1:0] {
    UMW_DEC_32 = 2'h0,
    UMW_DEC_64 = 2'h1
  } umw_dec_type;
endpackage

// File: pkg/umw_regs.svh
// Register offsets, field positions and reset values of the upstream windows
`ifndef UMW_REGS_SVH
`define UMW_REGS_SVH
// Byte offsets on the register bus
`define UMW_OFF_WSETUP_LO 12'h034
`define UMW_OFF_WSETUP_HI 12'h038
`define UMW_OFF_PBASE 12'h05C
`define UMW_OFF_WBASE_LO 12'h060
`define UMW_OFF_WBASE_HI 12'h064
`define UMW_OFF_FWD_CTL 12'h068
`define UMW_OFF_LUT_FIRST 12'h100
`define UMW_OFF_LUT_LAST 12'h1FF
// Forwarding control fields
`define UMW_CTL_PSIZE_LSB 16
`define UMW_CTL_PSIZE_W 4
`define UMW_CTL_A64_BIT 21
// Window base, setup enable and lookup entry valid fields
`define UMW_PBASE_LSB 14
`define UMW_WBASE_LSB 12
`define UMW_SETUP_EN_BIT 31
`define UMW_LUT_VALID_BIT 0
// Page size code 1 means 256 bytes, so page log2 is code plus this
`define UMW_PAGE_LOG2_OFS 5'h07
// 64 pages add six address bits on top of the page size
`define UMW_WIN_LOG2_OFS 5'h0D
// Reset values
`define UMW_RST_WORD 32'h0000_0000
`define UMW_RST_PSIZE 4'h0
`endif

// File: rtl/umw_top.sv
// Upstream paged and wide memory windows with APB register access
//
// Summary of operation
// - Paged base: space, type bits fixed, 13:4 zero
// - Paged base bits 31:14, 16KB-256MB, reset zero
// - Paged window split in 64 translated pages
// - Page size from forwarding control 4-bit field
// - Lookup entry bit 0 clear disables page
// - Writable paged base bits follow page size
// - Wide base reports type, prefetch, 11:4 zero
// - Wide size and type from low setup
// - Setup bit 31 clear disables wide window
// - Wide window size 4KB up to 4.6EB (setup bits 31 also compare address bits 31 and 63)
// - 64-bit control bit decodes both base words
// - No wide translation while 64-bit disabled
// - Secondary 64-bit outside downstream range goes upstream
// - Upper wide base separate, sized by setup
//
// Register access over APB was decided locally.
`include "umw_regs.svh"
`timescale 1ns/1ps
module umw_top
  import umw_pkg::*;
#(
  parameter int LUT_DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Upstream address lookup
  input wire logic up_valid,
  input wire logic [63:0] up_addr,
  output logic up_done,
  output logic up_paged_hit,
  output logic [5:0] up_page,
  output logic [31:0] up_paged_xlat,
  output logic up_wide_hit,
  // Secondary interface forwarding check
  input wire logic sec_valid,
  input wire logic [63:0] sec_addr,
  input wire logic sec_is64,
  input wire logic [63:0] dn3_base,
  input wire logic [63:0] dn3_limit,
  output logic sec_done,
  output logic sec_fwd_up
);

  // The lookup table spans exactly 256 bytes of register space
  if (LUT_DEPTH != 64) begin : g_depth_check
    $error("LUT_DEPTH must be 64");
  end

  // Mask of the bits below a power of two
  function automatic umw_word_type umw_low_mask(input logic [4:0] lg);
    umw_low_mask = (32'h0000_0001 << lg) - 32'h0000_0001;
  endfunction

  // True when every bit picked by the mask agrees
  function automatic logic umw_masked_eq(input umw_word_type a, input umw_word_type b,
    input umw_word_type m);
    umw_masked_eq = ((a ^ b) & m) == 32'h0000_0000;
  endfunction

  umw_word_type pbase_r;
  umw_word_type wbase_lo_r;
  umw_word_type wbase_hi_r;
  umw_word_type wsetup_lo_r;
  umw_word_type wsetup_hi_r;
  logic [3:0] psize_r;
  logic a64_en_r;
  umw_word_type lut_r [LUT_DEPTH];

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic up_done_r;
  logic up_paged_hit_r;
  logic [5:0] up_page_r;
  logic [31:0] up_paged_xlat_r;
  logic up_wide_hit_r;

  logic sec_done_r;
  logic sec_fwd_up_r;

  // Derived window geometry
  logic [4:0] page_log2;
  logic [4:0] win_log2;
  umw_word_type pbase_mask;
  umw_word_type wmask_lo;
  logic wide_en;
  umw_dec_type wide_type;
  logic setup_access;
  logic apb_wr;
  logic lut_sel;
  logic [5:0] lut_idx;

  always_comb begin
    page_log2 = psize_r + `UMW_PAGE_LOG2_OFS;
    win_log2 = psize_r + `UMW_WIN_LOG2_OFS;
    pbase_mask = ~umw_low_mask(win_log2);
    pbase_mask[`UMW_PBASE_LSB-1:0] = '0;
  end

  // Wide window geometry
  always_comb begin
    wmask_lo = {wsetup_lo_r[31:`UMW_WBASE_LSB], 12'h000};
    // Setup high bit 31 is also the mask bit of address bit 63
    // either setup bit disables
    wide_en = wsetup_lo_r[`UMW_SETUP_EN_BIT] & wsetup_hi_r[`UMW_SETUP_EN_BIT];
    wide_type = umw_dec_type'(wsetup_lo_r[2:1]);
  end

  assign setup_access = psel & ~penable;
  // Writes land in the access phase, gated by pready and decoding paddr again there
  assign apb_wr = psel & penable & pready_r & pwrite;
  assign lut_sel = (paddr >= `UMW_OFF_LUT_FIRST) && (paddr <= `UMW_OFF_LUT_LAST);
  assign lut_idx = paddr[7:2];

  // APB handshake: one wait-free access phase after each setup
  // Read data is latched at the setup edge, so the access phase never waits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `UMW_RST_WORD;
    end else begin
      pready_r <= setup_access;
      pslverr_r <= 1'b0;
      prdata_r <= `UMW_RST_WORD;
      if (setup_access) begin
        if (paddr[1:0] != 2'h0) begin
          pslverr_r <= 1'b1;
        end else if (lut_sel) begin
          prdata_r <= lut_r[lut_idx];
        end else begin
          unique case (paddr)
            `UMW_OFF_WSETUP_LO: prdata_r <= wsetup_lo_r;
            `UMW_OFF_WSETUP_HI: prdata_r <= wsetup_hi_r;
            `UMW_OFF_PBASE: prdata_r <= pbase_r & pbase_mask;
            `UMW_OFF_WBASE_LO: begin
              prdata_r <= (wbase_lo_r & wmask_lo) | {28'h0, wsetup_lo_r[3], wide_type, 1'b0};
            end
            `UMW_OFF_WBASE_HI: prdata_r <= wbase_hi_r & wsetup_hi_r;
            `UMW_OFF_FWD_CTL: begin
              prdata_r <= {10'h000, a64_en_r, 1'b0, psize_r, 16'h0000};
            end
            default: pslverr_r <= 1'b1;
          endcase
        end
      end
    end
  end

  // Window configuration registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pbase_r <= `UMW_RST_WORD;
      wbase_lo_r <= `UMW_RST_WORD;
      wbase_hi_r <= `UMW_RST_WORD;
      wsetup_lo_r <= `UMW_RST_WORD;
      wsetup_hi_r <= `UMW_RST_WORD;
      psize_r <= `UMW_RST_PSIZE;
      a64_en_r <= 1'b0;
    end else if (apb_wr && paddr[1:0] == 2'h0) begin
      unique case (paddr)
        `UMW_OFF_WSETUP_LO: wsetup_lo_r <= pwdata;
        `UMW_OFF_WSETUP_HI: wsetup_hi_r <= pwdata;
        `UMW_OFF_PBASE: pbase_r <= pwdata & pbase_mask;
        // Low base keeps bits 31:12; the setup mask acts on read and decode
        // any setup mask from 4KB up
        `UMW_OFF_WBASE_LO: wbase_lo_r <= {pwdata[31:`UMW_WBASE_LSB], 12'h000};
        `UMW_OFF_WBASE_HI: wbase_hi_r <= pwdata;
        // A new page size resizes the paged window at once
        `UMW_OFF_FWD_CTL: begin
          psize_r <= pwdata[`UMW_CTL_PSIZE_LSB +: `UMW_CTL_PSIZE_W];
          a64_en_r <= pwdata[`UMW_CTL_A64_BIT];
        end
        default: ;
      endcase
    end
  end

  // Lookup table entries
  // Reset clears every entry, so no page is claimed before software fills it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < LUT_DEPTH; i++) begin
        lut_r[i] <= `UMW_RST_WORD;
      end
    end else if (apb_wr && lut_sel && paddr[1:0] == 2'h0) begin
      lut_r[lut_idx] <= pwdata;
    end
  end

  // Upstream decode, one cycle from request to result
  umw_word_type up_lo;
  umw_word_type page_off_mask;
  umw_word_type page_word;
  umw_word_type page_shift;
  logic [5:0] page_idx;
  logic paged_match;
  logic wide_match;

  always_comb begin
    up_lo = up_addr[31:0];
    page_off_mask = umw_low_mask(page_log2);
    page_shift = up_lo >> page_log2;
    page_idx = page_shift[5:0];
    page_word = lut_r[page_idx];
    // The paged window is 32-bit only, so upper address bits must be zero
    // enabled and masked bits equal
    paged_match = (psize_r != 4'h0) && (up_addr[63:32] == 32'h0000_0000)
      && umw_masked_eq(up_lo, pbase_r, pbase_mask);
    // Both windows may claim one address; the core above picks one
    // both words decoded
    wide_match = wide_en && a64_en_r && umw_masked_eq(up_lo, wbase_lo_r, wmask_lo)
      && umw_masked_eq(up_addr[63:32], wbase_hi_r, wsetup_hi_r);
  end

  // Lookup strobe, one cycle behind the request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      up_done_r <= 1'b0;
    end else begin
      up_done_r <= up_valid;
    end
  end

  // Paged window result
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      up_paged_hit_r <= 1'b0;
      up_page_r <= 6'h00;
      up_paged_xlat_r <= `UMW_RST_WORD;
    end else begin
      up_paged_hit_r <= up_valid & paged_match & page_word[`UMW_LUT_VALID_BIT];
      up_page_r <= page_idx;
      up_paged_xlat_r <= (page_word & ~page_off_mask) | (up_lo & page_off_mask);
    end
  end

  // Wide window result
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      up_wide_hit_r <= 1'b0;
    end else begin
      // no wide claim when 64-bit off
      up_wide_hit_r <= up_valid & wide_match;
    end
  end

  // Secondary strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sec_done_r <= 1'b0;
    end else begin
      sec_done_r <= sec_valid;
    end
  end

  // Secondary side forwarding check, downstream range inclusive at both ends
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sec_fwd_up_r <= 1'b0;
    end else begin
      sec_fwd_up_r <= sec_valid & sec_is64 & ~((sec_addr >= dn3_base) && (sec_addr <= dn3_limit));
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  assign up_done = up_done_r;
  assign up_paged_hit = up_paged_hit_r;
  assign up_page = up_page_r;
  assign up_paged_xlat = up_paged_xlat_r;
  assign up_wide_hit = up_wide_hit_r;

  assign sec_done = sec_done_r;
  assign sec_fwd_up = sec_fwd_up_r;

endmodule

// File: sim/testbench.sv
// Self-checking bench of the upstream memory windows
`timescale 1ns/1ps
module testbench import umw_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset_n, psel, penable, pwrite, pready, pslverr, up_valid, up_done, up_paged_hit;
  logic up_wide_hit, sec_valid, sec_is64, sec_done, sec_fwd_up;
  logic [11:0] paddr;
  logic [5:0] up_page;
  logic [63:0] addr;
  umw_word_type pwdata, prdata, up_paged_xlat, rd;
  logic err;
  logic [63:0] dn3_base = 64'h1_0000_0000;
  logic [63:0] dn3_limit = 64'h1_FFFF_FFFF;
  int num_errors = 0, n_tests = 0;
  umw_top u_umw_top (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .up_valid, .up_addr(addr), .up_done, .up_paged_hit, .up_page,
    .up_paged_xlat, .up_wide_hit, .sec_valid, .sec_addr(addr), .sec_is64, .sec_done,
    .dn3_base, .dn3_limit, .sec_fwd_up);
  umw_host u_umw_host (.clk_sys, .up_valid, .sec_valid, .sec_is64, .addr);
  initial forever #12.5 clk_sys = ~clk_sys;
  initial #40000 begin
    num_errors++;
    summarize();
  end
  task chk(input string s, input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input umw_word_type d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task lk(input logic [63:0] a, input logic ph, input logic wh);
    u_umw_host.send(1'b0, 1'b0, a);
    chk("paged hit", up_paged_hit, ph);
    chk("wide hit", up_wide_hit, wh);
  endtask
  task sk(input logic w, input logic [63:0] a, input logic fw);
    u_umw_host.send(1'b1, w, a);
    chk("forward up", sec_fwd_up, fw);
  endtask
  task t_paged;
    apb(1'b0, 12'h05C, 32'h0);
    chk("base reset", rd, 32'h0);
    apb(1'b1, 12'h068, 32'h0005_0000);
    apb(1'b1, 12'h05C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h05C, 32'h0);
    chk("paged base", rd, 32'hFFFC_0000);
    apb(1'b1, 12'h05C, 32'h0004_0000);
    apb(1'b1, 12'h10C, 32'hABCD_0001);
    apb(1'b0, 12'h10C, 32'h0);
    chk("entry", rd, 32'hABCD_0001);
    lk(64'h4_3123, 1'b1, 1'b0);
    chk("page", up_page, 6'h03);
    chk("xlat", up_paged_xlat, 32'hABCD_0123);
    lk(64'h4_4123, 1'b0, 1'b0);
    lk(64'h8_3123, 1'b0, 1'b0);
    apb(1'b1, 12'h068, 32'h0004_0000);
    lk(64'h4_1DFF, 1'b1, 1'b0);
    chk("xlat small", up_paged_xlat, 32'hABCD_05FF);
  endtask
  task t_wide;
    apb(1'b1, 12'h034, 32'hFFFF_F00A);
    apb(1'b1, 12'h038, 32'hFFFF_FFFF);
    apb(1'b1, 12'h060, 32'h1234_5FFF);
    apb(1'b0, 12'h060, 32'h0);
    chk("wide base", rd, 32'h1234_500A);
    apb(1'b1, 12'h064, 32'h8000_0009);
    apb(1'b0, 12'h064, 32'h0);
    chk("upper base", rd, 32'h8000_0009);
    lk(64'h8000_0009_1234_5678, 1'b0, 1'b0);
    apb(1'b1, 12'h068, 32'h0025_0000);
    lk(64'h8000_0009_1234_5678, 1'b0, 1'b1);
    apb(1'b1, 12'h034, 32'hFFFF_000A);
    apb(1'b0, 12'h060, 32'h0);
    chk("wide size", rd, 32'h1234_000A);
    lk(64'h8000_0009_1234_F678, 1'b0, 1'b1);
    apb(1'b1, 12'h038, 32'h7FFF_FFFF);
    lk(64'h8000_0009_1234_F678, 1'b0, 1'b0);
    apb(1'b1, 12'h038, 32'hFFFF_FFFF);
    apb(1'b1, 12'h034, 32'h7FFF_F00A);
    lk(64'h8000_0009_1234_5678, 1'b0, 1'b0);
  endtask
  task t_sec;
    apb(1'b0, 12'h05E, 32'h0);
    chk("unaligned error", err, 1'b1);
    chk("unaligned data", rd, 32'h0);
    apb(1'b0, 12'h070, 32'h0);
    chk("unmapped error", err, 1'b1);
    sk(1'b1, 64'h1_0000_0010, 1'b0);
    sk(1'b1, 64'h2_0000_0000, 1'b1);
    sk(1'b1, 64'h0_FFFF_FFFF, 1'b1);
    sk(1'b0, 64'h2_0000_0000, 1'b0);
    @(posedge clk_sys);
    dn3_limit <= 64'h1_0000_000F;
    sk(1'b1, 64'h1_0000_0010, 1'b1);
    sk(1'b1, 64'h1_0000_000F, 1'b0);
  endtask
  task summarize;
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_paged();
    t_wide();
    t_sec();
    summarize();
  end
endmodule

// File: sim/umw_host.sv
// Far-side host issuing upstream and secondary lookups
`timescale 1ns/1ps
module umw_host (
  // Clock
  input logic clk_sys,
  // Lookup requests
  output logic up_valid = 1'b0,
  output logic sec_valid = 1'b0,
  output logic sec_is64 = 1'b0,
  output logic [63:0] addr = 64'h0
);
  // Address inverted after the pulse so nothing stale looks valid
  task send(input logic sec, input logic w, input logic [63:0] a);
    @(posedge clk_sys);
    up_valid <= !sec;
    sec_valid <= sec;
    sec_is64 <= w;
    addr <= a;
    @(posedge clk_sys);
    up_valid <= 1'b0;
    sec_valid <= 1'b0;
    addr <= ~a;
    #1;
  endtask
endmodule

// File: sim/umw_props.sv
// Port checker of the upstream window block
`timescale 1ns/1ps
module umw_props #(parameter int LUT_DEPTH = 64) (
  // Clock, reset and register bus
  input logic clk_sys,
  input logic reset_n,
  input logic psel,
  input logic penable,
  input logic [11:0] paddr,
  input logic pready,
  input logic pslverr,
  // Lookups
  input logic up_valid,
  input logic up_done,
  input logic up_paged_hit,
  input logic up_wide_hit,
  input logic sec_valid,
  input logic sec_is64,
  input logic sec_done,
  input logic sec_fwd_up
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("no slave error");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_up_latency: assert property (up_valid |=> up_done) else $error("lookup late");
  a_up_cause: assert property (up_done |-> $past(up_valid)) else $error("stray done");
  a_hit_quiet: assert property (!up_done |-> !up_paged_hit && !up_wide_hit)
    else $error("stray hit");
  a_sec_latency: assert property (sec_valid |=> sec_done) else $error("check late");
  a_sec_narrow: assert property (!(sec_done && $past(sec_is64)) |-> !sec_fwd_up)
    else $error("narrow forwarded");
endmodule
bind umw_top umw_props #(.LUT_DEPTH(LUT_DEPTH)) u_props (.clk_sys, .reset_n, .psel, .penable,
  .paddr, .pready, .pslverr, .up_valid, .up_done, .up_paged_hit, .up_wide_hit, .sec_valid,
  .sec_is64, .sec_done, .sec_fwd_up);
